// [rtl/mic_pkg.sv]
// package: constants and types for the measurement initiation controller
package mic_pkg;
    localparam logic [15:0] MIC_ERR_NONE = 16'h0000;
    // error codes as twos complement of -213 and -210
    localparam logic [15:0] MIC_ERR_INIT_IGNORED = 16'hFF2B;
    localparam logic [15:0] MIC_ERR_TRIGGER = 16'hFF2E;
    localparam logic [7:0] MIC_ASCII_ZERO = 8'h30;
    localparam logic [7:0] MIC_ASCII_ONE = 8'h31;
    localparam int MIC_OPSTAT_STATS_BIT = 8;
    localparam int MIC_COUNT_W = 16;
    localparam logic [15:0] MIC_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] MIC_ONE_MEAS = 16'h0001;

    // trigger-action choices for the group execute trigger
    typedef enum logic [1:0] {
        MIC_ACT_NONE,
        MIC_ACT_SINGLE,
        MIC_ACT_CONT_ON,
        MIC_ACT_ABORT
    } mic_act_t;

    // boolean settings that can be queried
    typedef enum logic [2:0] {
        MIC_Q_CONT,
        MIC_Q_STOP_ON_FAIL,
        MIC_Q_AUTO_BLOCK,
        MIC_Q_STATS,
        MIC_Q_LIMIT_TEST,
        MIC_Q_LIMIT_CLR,
        MIC_Q_AUTO_LEVEL,
        MIC_Q_BUSY
    } mic_query_t;

    typedef enum logic [1:0] {
        MIC_IDLE,
        MIC_SINGLE,
        MIC_BLOCK,
        MIC_CONT
    } mic_state_t;
endpackage

// [rtl/mic_ctrl.sv]
// measurement initiation controller: start, stop, block and continuous runs
// Contract
// - trigger performs the previously defined trigger action
// - limit failure clears continuous run when enabled
// - stop-on-fail only with limit test and continuous
// - command reset clears both; power-up sets continuous
// - no start while idle without single initiate or continuous on
// - continuous start, then restart on each done
// - continuous start clears statistics and stats bit
// - auto clear wipes limit results on initiate
// - auto trigger channel one on each start except block repeats and the power-up start
// - continuous run ignores block count, one each
// - continuous pending flag set, cleared on end
// - abort in continuous restarts while still enabled
// - mode change during single raises error codes
// - block only with block count, stats, non-peaks
// - block initiate clears statistics first
// - initiate while busy or continuous is error
// - single initiate pending flag, cleared on end
// - initiate is overlapped, commands still accepted
// - boolean query returns ascii zero or one
`timescale 1ns/100ps
module mic_ctrl
    import mic_pkg::*;
#(
    parameter int BLOCK_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_rst,
    input wire logic get_pulse,
    input wire logic listen_addressed,
    input wire logic act_define,
    input wire mic_act_t act_value,
    input wire logic single_initiate,
    input wire logic cont_on_cmd,
    input wire logic cont_off_cmd,
    input wire logic stop_fail_wr,
    input wire logic stop_fail_val,
    input wire logic abort_cmd,
    input wire logic auto_block_count,
    input wire logic statistics_enable,
    input wire logic limit_test_enable,
    input wire logic limit_auto_clear,
    input wire logic auto_trigger_level,
    input wire logic chan1_measuring,
    input wire logic volt_peaks_func,
    input wire logic [BLOCK_W-1:0] block_size,
    input wire logic limit_fail_event,
    input wire logic meas_done,
    input wire logic query_strobe,
    input wire mic_query_t query_sel,
    output logic meas_start,
    output logic meas_abort,
    output logic auto_trig,
    output logic stats_clear,
    output logic limit_clear,
    output logic limit_indicator_off,
    output logic continuous_run,
    output logic stop_on_limit_fail,
    output logic pending_op,
    output logic busy,
    output logic computing_stats,
    output logic [15:0] err_code,
    output logic err_valid,
    output logic [7:0] query_char,
    output logic query_valid,
    output logic cmd_ready
);
    // ==========================================================
    // state
    mic_state_t state_reg, state_next;
    mic_act_t act_reg;
    logic cont_reg, cont_next;
    logic sof_reg, sof_next;
    logic [BLOCK_W-1:0] left_reg, left_next;
    logic pend_reg, pend_next;
    logic power_up_reg;
    // busy has its own flop so the pin never shows a state decode
    logic busy_reg;

    function automatic logic [7:0] mic_bool_char(input logic b);
        return b ? MIC_ASCII_ONE : MIC_ASCII_ZERO;
    endfunction

    // ==========================================================
    // decode
    wire get_act = get_pulse && listen_addressed;
    wire do_single = single_initiate || (get_act && act_reg == MIC_ACT_SINGLE);
    wire do_cont_on = cont_on_cmd || (get_act && act_reg == MIC_ACT_CONT_ON);
    wire do_abort = abort_cmd || (get_act && act_reg == MIC_ACT_ABORT);
    wire running = (state_reg != MIC_IDLE);
    wire in_single = (state_reg == MIC_SINGLE) || (state_reg == MIC_BLOCK);
    wire single_ok = do_single && !running && !cont_reg;
    wire single_bad = do_single && !single_ok;
    wire block_mode = auto_block_count && statistics_enable && !volt_peaks_func;
    wire cont_on_bad = do_cont_on && in_single;
    wire cont_off_bad = cont_off_cmd && in_single;
    wire cont_rise = do_cont_on && !cont_reg && !in_single;
    wire fail_stop = limit_fail_event && sof_reg && limit_test_enable && cont_reg;
    wire done_last = (state_reg == MIC_BLOCK) ? (left_reg <= BLOCK_W'(MIC_ONE_MEAS)) : 1'b1;
    wire cont_again = (state_reg == MIC_CONT) && cont_next && (meas_done || do_abort);
    // a block keeps the core going until its count is used up or an abort ends it
    wire block_again = (state_reg == MIC_BLOCK) && meas_done && !done_last && !do_abort;
    wire do_start = single_ok || cont_rise || cont_again || block_again;
    wire aux_trig = auto_trigger_level && chan1_measuring && (single_ok || cont_rise || cont_again);
    wire lim_clr = limit_auto_clear && (single_ok || cont_rise);
    wire st_clr = cont_rise || (single_ok && auto_block_count && statistics_enable);

    always_comb begin
        cont_next = cont_reg;
        if (cont_rise) begin
            cont_next = 1'b1;
        end else if (cont_off_cmd && !in_single) begin
            cont_next = 1'b0;
        end
        if (fail_stop) begin
            cont_next = 1'b0;
        end
        sof_next = stop_fail_wr ? stop_fail_val : sof_reg;
    end

    always_comb begin
        state_next = state_reg;
        left_next = left_reg;
        pend_next = pend_reg;
        unique case (state_reg)
            MIC_IDLE: begin
                if (single_ok && block_mode) begin
                    state_next = MIC_BLOCK;
                    left_next = block_size;
                    pend_next = 1'b1;
                end else if (single_ok) begin
                    state_next = MIC_SINGLE;
                    pend_next = 1'b1;
                end else if (cont_rise) begin
                    state_next = MIC_CONT;
                    pend_next = 1'b1;
                end
            end
            MIC_SINGLE, MIC_BLOCK: begin
                if (do_abort || (meas_done && done_last)) begin
                    state_next = MIC_IDLE;
                    pend_next = 1'b0;
                end else if (meas_done) begin
                    left_next = left_reg - BLOCK_W'(MIC_ONE_MEAS);
                end
            end
            MIC_CONT: begin
                // one measurement per cycle regardless of block setting
                if (do_abort) begin
                    pend_next = 1'b0;
                    if (!cont_next) begin
                        state_next = MIC_IDLE;
                    end
                end else if (meas_done && !cont_next) begin
                    state_next = MIC_IDLE;
                    pend_next = 1'b0;
                end
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_up_reg <= 1'b1;
            state_reg <= MIC_IDLE;
            cont_reg <= 1'b0;
            sof_reg <= 1'b0;
            left_reg <= '0;
            pend_reg <= 1'b0;
            act_reg <= MIC_ACT_SINGLE;
            busy_reg <= 1'b0;
        end else if (power_up_reg) begin
            // continuous run from power-on, starting the first measurement
            power_up_reg <= 1'b0;
            busy_reg <= 1'b1;
            cont_reg <= 1'b1;
            state_reg <= MIC_CONT;
            pend_reg <= 1'b1;
        end else if (cmd_rst) begin
            cont_reg <= 1'b0;
            sof_reg <= 1'b0;
            state_reg <= MIC_IDLE;
            pend_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= (state_next != MIC_IDLE);
            cont_reg <= cont_next;
            sof_reg <= sof_next;
            left_reg <= left_next;
            pend_reg <= pend_next;
            if (act_define) begin
                act_reg <= act_value;
            end
        end
    end

    wire pu_start = power_up_reg;
    wire [15:0] err_sel = (single_bad || cont_on_bad) ? MIC_ERR_INIT_IGNORED :
                          cont_off_bad ? MIC_ERR_TRIGGER : MIC_ERR_NONE;
    logic [7:0] q_char;
    always_comb begin
        unique case (query_sel)
            MIC_Q_CONT: q_char = mic_bool_char(cont_reg);
            MIC_Q_STOP_ON_FAIL: q_char = mic_bool_char(sof_reg);
            MIC_Q_AUTO_BLOCK: q_char = mic_bool_char(auto_block_count);
            MIC_Q_STATS: q_char = mic_bool_char(statistics_enable);
            MIC_Q_LIMIT_TEST: q_char = mic_bool_char(limit_test_enable);
            MIC_Q_LIMIT_CLR: q_char = mic_bool_char(limit_auto_clear);
            MIC_Q_AUTO_LEVEL: q_char = mic_bool_char(auto_trigger_level);
            MIC_Q_BUSY: q_char = mic_bool_char(running);
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meas_start <= 1'b0;
            meas_abort <= 1'b0;
            auto_trig <= 1'b0;
            stats_clear <= 1'b0;
            limit_clear <= 1'b0;
            limit_indicator_off <= 1'b0;
            computing_stats <= 1'b0;
            err_code <= MIC_ERR_NONE;
            err_valid <= 1'b0;
            query_char <= MIC_ASCII_ZERO;
            query_valid <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            meas_start <= pu_start || (!power_up_reg && !cmd_rst && do_start);
            meas_abort <= !power_up_reg && do_abort && running;
            auto_trig <= !power_up_reg && !cmd_rst && aux_trig;
            stats_clear <= pu_start || (!cmd_rst && st_clr);
            limit_clear <= !cmd_rst && lim_clr;
            limit_indicator_off <= !cmd_rst && lim_clr;
            if (st_clr || pu_start) begin
                computing_stats <= 1'b0;
            end else if (statistics_enable && running) begin
                computing_stats <= 1'b1;
            end
            err_code <= err_sel;
            err_valid <= (err_sel != MIC_ERR_NONE);
            query_char <= q_char;
            query_valid <= query_strobe;
            cmd_ready <= 1'b1;
        end
    end

    assign continuous_run = cont_reg;
    assign stop_on_limit_fail = sof_reg;
    assign pending_op = pend_reg;
    assign busy = busy_reg;

    // ==========================================================
    // checks
    cont_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cont_rise && !cmd_rst && !power_up_reg) |=> meas_start && pend_reg) else $error("no start on cont");
    fail_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fail_stop && !cmd_rst && !power_up_reg) |=> !cont_reg) else $error("fail did not stop");
    fail_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        (limit_fail_event && (!sof_reg || !limit_test_enable) && !do_cont_on && !cont_off_cmd && !cmd_rst
        && !power_up_reg) |=> cont_reg == $past(cont_reg)) else $error("fail changed cont");
    busy_init_a: assert property (@(posedge clk) disable iff (sys_rst)
        (single_initiate && (running || cont_reg)) |=> err_valid && err_code == MIC_ERR_INIT_IGNORED)
        else $error("missing -213");
    cont_err_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cont_off_cmd && in_single && !do_single && !do_cont_on) |=> err_code == MIC_ERR_TRIGGER)
        else $error("missing -210");
    idle_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MIC_IDLE && !cont_reg && !do_single && !do_cont_on && !power_up_reg) |=> !meas_start)
        else $error("start while idle");
    cmd_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_rst && !power_up_reg) |=> !cont_reg && !sof_reg && !pend_reg) else $error("cmd reset");
    single_pend_a: assert property (@(posedge clk) disable iff (sys_rst)
        (single_ok && !cmd_rst && !power_up_reg) |=> pend_reg ##0 meas_start) else $error("pending");
    query_char_a: assert property (@(posedge clk) disable iff (sys_rst)
        query_strobe |=> query_valid && (query_char == MIC_ASCII_ZERO || query_char == MIC_ASCII_ONE))
        else $error("bad query char");
    start_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        (meas_start && state_reg != MIC_CONT) |=> !meas_start) else $error("long start");
    abort_cont_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MIC_CONT && do_abort && cont_next && !cmd_rst) |=> meas_abort && meas_start && !pend_reg)
        else $error("abort did not restart");
    cont_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MIC_CONT && meas_done && cont_next && !do_abort && !cmd_rst) |=> meas_start
        && state_reg == MIC_CONT) else $error("no restart on done");
    cont_end_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MIC_CONT && meas_done && !cont_next && !do_abort && !cmd_rst) |=> !pend_reg && !busy)
        else $error("last done left pending");
    stats_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cont_rise && !cmd_rst && !power_up_reg) |=> stats_clear && !computing_stats) else $error("stats kept");
    limit_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (limit_auto_clear && (single_ok || cont_rise) && !cmd_rst && !power_up_reg) |=> limit_clear
        && limit_indicator_off) else $error("limit results kept");
    auto_trig_a: assert property (@(posedge clk) disable iff (sys_rst)
        (auto_trigger_level && chan1_measuring && (single_ok || cont_rise) && !cmd_rst && !power_up_reg)
        |=> auto_trig) else $error("no auto trigger");
    block_next_a: assert property (@(posedge clk) disable iff (sys_rst)
        (block_again && !cmd_rst) |=> meas_start && busy) else $error("block stalled");
    single_end_a: assert property (@(posedge clk) disable iff (sys_rst)
        (in_single && (do_abort || (meas_done && done_last)) && !cmd_rst) |=> !pend_reg && !busy)
        else $error("single left pending");
    cover_block_c: cover property (@(posedge clk) disable iff (sys_rst) state_reg == MIC_BLOCK ##1 state_reg == MIC_IDLE);
    cover_get_c: cover property (@(posedge clk) disable iff (sys_rst) get_act && act_reg == MIC_ACT_CONT_ON);
    cover_cont_c: cover property (@(posedge clk) disable iff (sys_rst) cont_rise ##[1:20] meas_done);
    cover_abort_c: cover property (@(posedge clk) disable iff (sys_rst) state_reg == MIC_CONT && do_abort && cont_reg);
endmodule

// [tb/mic_core_model.sv]
// measurement core model: answers each start with a done after a set delay, unless an abort or a newer start comes first
`timescale 1ns/100ps
module mic_core_model #(
    parameter int DLY = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic meas_start,
    input wire logic meas_abort,
    output logic meas_done
);
    int cnt_reg;
    // ==========================================
    // core handshake
    // a new start restarts the count, so an abort and restart in one cycle keeps running
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= 0;
            meas_done <= 1'b0;
        end else begin
            meas_done <= (cnt_reg == 1);
            if (meas_start) begin
                cnt_reg <= DLY;
            end else if (meas_abort) begin
                cnt_reg <= 0;
            end else if (cnt_reg > 0) begin
                cnt_reg <= cnt_reg - 1;
            end
        end
    end
endmodule

// [tb/measurement_initiation_control_tb.sv]
// self-checking bench for the measurement initiation controller
`timescale 1ns/100ps
module measurement_initiation_control_tb;
    import mic_pkg::*;
    localparam int SI = 0, CON = 1, COFF = 2, ABT = 3, GET = 4, DEF = 5, SFW = 6, LFE = 7, QRY = 8, RST = 9;
    localparam int DLY = 16;
    logic clk = 1'b0, sys_rst = 1'b1;
    logic [9:0] cv = '0;
    logic listen = 1'b0, sfv = 1'b0, abc = 1'b0, sen = 1'b0, lte = 1'b0, lac = 1'b0, atl = 1'b0, ch1 = 1'b0, vpk = 1'b0;
    mic_act_t act = MIC_ACT_NONE;
    mic_query_t qsel = MIC_Q_CONT;
    logic [15:0] bsize = 16'h0001;
    logic done, start, abort, atrig, sclr, lclr, cont, sof, pend, busy, cstat, errv, lio, qv, rdy;
    logic [15:0] errc;
    logic [7:0] qch;
    int fail_count = 0, tests_run = 0, n_start = 0, cyc = 0;
    // ==========================================
    // clock, design and partner
    initial begin
        forever #20 clk = ~clk;
    end
    mic_ctrl uut (.clk(clk), .sys_rst(sys_rst), .cmd_rst(cv[RST]), .get_pulse(cv[GET]), .listen_addressed(listen),
        .act_define(cv[DEF]), .act_value(act), .single_initiate(cv[SI]), .cont_on_cmd(cv[CON]),
        .cont_off_cmd(cv[COFF]), .stop_fail_wr(cv[SFW]), .stop_fail_val(sfv), .abort_cmd(cv[ABT]),
        .auto_block_count(abc), .statistics_enable(sen), .limit_test_enable(lte), .limit_auto_clear(lac),
        .auto_trigger_level(atl), .chan1_measuring(ch1), .volt_peaks_func(vpk), .block_size(bsize),
        .limit_fail_event(cv[LFE]), .meas_done(done), .query_strobe(cv[QRY]), .query_sel(qsel),
        .meas_start(start), .meas_abort(abort), .auto_trig(atrig), .stats_clear(sclr), .limit_clear(lclr),
        .limit_indicator_off(lio), .continuous_run(cont), .stop_on_limit_fail(sof), .pending_op(pend), .busy(busy),
        .computing_stats(cstat), .err_code(errc), .err_valid(errv), .query_char(qch), .query_valid(qv),
        .cmd_ready(rdy));
    mic_core_model #(.DLY(DLY)) core (.clk(clk), .sys_rst(sys_rst), .meas_start(start), .meas_abort(abort),
        .meas_done(done));
    // ==========================================
    // helpers
    always @(posedge clk) begin
        if (start === 1'b1) n_start++;
        cyc++;
        // the whole sequence needs well under a thousand cycles
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle command pulse; returns in the cycle that shows the answer
    task automatic cmd(input int k);
        @(negedge clk) cv[k] = 1'b1;
        @(negedge clk) cv = '0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    initial begin
        idle(6);
        sys_rst = 1'b0;
        idle(3);
        check("powerup_cont", cont, 1'b1);
        check("powerup_pend", pend, 1'b1);
        cmd(RST);
        check("rst_cont", {cont, sof, pend}, 3'b000);
        idle(DLY + 2);
        n_start = 0;
        idle(20);
        check("idle_starts", n_start, 0);
        lac = 1'b1; atl = 1'b1; ch1 = 1'b1;
        cmd(SI);
        check("single_start", {start, lclr, lio, atrig, pend, busy}, 6'h3F);
        cmd(SI);
        check("single_busy_err", {errv, errc}, {1'b1, MIC_ERR_INIT_IGNORED});
        cmd(CON);
        check("con_in_single", {errv, errc, cont}, {1'b1, MIC_ERR_INIT_IGNORED, 1'b0});
        cmd(COFF);
        check("coff_in_single", {errv, errc, rdy}, {1'b1, MIC_ERR_TRIGGER, 1'b1});
        cmd(QRY);
        check("query_off", {qv, qch}, {1'b1, MIC_ASCII_ZERO});
        idle(DLY);
        check("single_end", {pend, busy}, 2'b00);
        sen = 1'b1;
        cmd(CON);
        check("con_start", {cont, sclr, start, lclr, atrig, cstat}, 6'b111110);
        cmd(QRY);
        check("query_on", {qv, qch}, {1'b1, MIC_ASCII_ONE});
        check("stats_busy", cstat, 1'b1);
        cmd(SI);
        check("single_in_cont", {errv, errc}, {1'b1, MIC_ERR_INIT_IGNORED});
        abc = 1'b1; bsize = 16'h0003;
        n_start = 0;
        idle(3 * DLY + 8);
        check("cont_restarts", n_start >= 3, 1'b1);
        cmd(ABT);
        check("abort_restart", {abort, start, cont, pend}, 4'b1110);
        lte = 1'b1;
        cmd(SFW);
        cmd(LFE);
        check("fail_no_stop", {sof, cont}, 2'b01);
        sfv = 1'b1;
        cmd(SFW);
        cmd(LFE);
        check("fail_stop", {sof, cont}, 2'b10);
        idle(DLY + 4);
        check("cont_last_done", {pend, busy}, 2'b00);
        lte = 1'b0;
        cmd(CON);
        cmd(LFE);
        check("stop_needs_limit", cont, 1'b1);
        cmd(COFF);
        check("coff", cont, 1'b0);
        idle(DLY + 4);
        n_start = 0;
        cmd(SI);
        check("block_clear", {sclr, pend}, 2'b11);
        idle(3 * DLY + 10);
        check("block_count", {n_start[3:0], pend}, {4'h3, 1'b0});
        vpk = 1'b1;
        n_start = 0;
        cmd(SI);
        idle(DLY + 6);
        check("peaks_single", n_start, 1);
        act = MIC_ACT_SINGLE;
        cmd(DEF);
        cmd(GET);
        check("get_unlistened", start, 1'b0);
        listen = 1'b1;
        cmd(GET);
        check("get_single", {start, cont}, 2'b10);
        idle(DLY + 4);
        act = MIC_ACT_CONT_ON;
        cmd(DEF);
        cmd(GET);
        check("get_cont", {start, cont}, 2'b11);
        act = MIC_ACT_ABORT;
        cmd(DEF);
        cmd(GET);
        check("get_abort", {abort, start, cont, pend}, 4'b1110);
        qsel = MIC_Q_STOP_ON_FAIL;
        cmd(QRY);
        check("query_sof", {qv, qch}, {1'b1, MIC_ASCII_ONE});
        end_of_test();
    end
endmodule
